// File: common/cecc_pkg.sv
package cecc_pkg;

  // Register byte addresses.
  localparam logic [31:0] CECC_ADDR_ENABLE = 32'h4004_0300;
  localparam logic [31:0] CECC_ADDR_LADDR = 32'h4004_0304;
  localparam logic [31:0] CECC_ADDR_SRESET = 32'h4004_0308;
  localparam logic [31:0] CECC_ADDR_RXEN = 32'h4004_030c;
  localparam logic [31:0] CECC_ADDR_RXBUF = 32'h4004_0310;
  localparam logic [31:0] CECC_ADDR_RCFG1 = 32'h4004_0314;
  localparam logic [31:0] CECC_ADDR_RCFG2 = 32'h4004_0318;
  localparam logic [31:0] CECC_ADDR_RCFG3 = 32'h4004_031c;
  localparam logic [31:0] CECC_ADDR_TXEN = 32'h4004_0320;
  localparam logic [31:0] CECC_ADDR_TXBUF = 32'h4004_0324;
  localparam logic [31:0] CECC_ADDR_TXCFG = 32'h4004_0328;
  localparam logic [31:0] CECC_ADDR_RXSTAT = 32'h4004_032c;
  localparam logic [31:0] CECC_ADDR_TXSTAT = 32'h4004_0330;
  localparam logic [31:0] CECC_ADDR_IMASK = 32'h4004_0334;

  // Field positions.
  localparam int CECC_EN_MODULE_BIT = 0;
  localparam int CECC_EN_IDLE_BIT = 1;
  localparam int CECC_SRESET_BIT = 0;
  localparam int CECC_RXEN_BIT = 0;
  localparam int CECC_BUF_EOM_BIT = 8;
  localparam int CECC_BUF_ACK_BIT = 9;
  localparam int CECC_STAT_DONE_BIT = 0;
  localparam int CECC_STAT_ERR_BIT = 1;
  localparam logic [3:0] CECC_BROADCAST = 4'hf;
  localparam logic [3:0] CECC_LAST_BIT = 4'h9;

  // Values after reset.
  localparam logic [15:0] CECC_LADDR_RST = 16'h0000;
  localparam logic [31:0] CECC_CFG_RST = 32'h0000_0000;
  localparam logic [9:0] CECC_RXBUF_RST = 10'h000;

  // Sampling clock derived from the 100 MHz system clock.
  localparam int CECC_CLK_HZ = 100_000_000;
  localparam int CECC_SAMPLE_HZ = 32_000;
  localparam int CECC_TICK_DIV = CECC_CLK_HZ / CECC_SAMPLE_HZ;
  localparam logic [11:0] CECC_TICK_LAST = 12'(CECC_TICK_DIV - 1);

  // Line timing in microseconds, converted to sample ticks.
  localparam int CECC_START_MIN_US = 3500;
  localparam int CECC_SAMPLE_US = 1050;
  localparam int CECC_ACK_HOLD_US = 1500;
  localparam int CECC_TIMEOUT_US = 2750;
  localparam logic [7:0] CECC_START_MIN_TICKS =
    8'((CECC_START_MIN_US * 32 + 999) / 1000);
  localparam logic [7:0] CECC_SAMPLE_TICKS =
    8'((CECC_SAMPLE_US * 32 + 999) / 1000);
  localparam logic [7:0] CECC_ACK_HOLD_TICKS =
    8'((CECC_ACK_HOLD_US * 32 + 999) / 1000);
  localparam logic [7:0] CECC_TIMEOUT_TICKS =
    8'((CECC_TIMEOUT_US * 32) / 1000);

  typedef enum logic [1:0] {
    CECC_RX_IDLE,
    CECC_RX_START,
    CECC_RX_WAIT,
    CECC_RX_BIT
  } cecc_rx_state_e;

endpackage

// File: design/cecc_ctrl.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RQ1: Fourteen registers at consecutive word addresses.
// RQ2: Module disabled freezes all but enable register.
// RQ3: Disabling keeps every programmed register value.
// RQ4: Idle-run bit keeps block alive in IDLE.
// RQ5: Both enable bits may be written together.
// RQ6: Address map bit n claims logical address n.
// RQ7: Broadcast frames are received regardless of map.
// RQ8: Map bit 15 makes broadcasts acknowledged low.
// RQ9: Soft reset aborts reception, discards data.
// RQ10: Soft reset stops transmit and releases line.
// RQ11: Soft reset clears all registers but enable.
// RQ12: Receive enable read shows actual receiver state.
// RQ13: Software programs receive setup before enabling.
// RQ14: Software stops traffic before changing settings.
// RQ15: Buffer holds byte, EOM bit 8, ACK bit 9.
// RQ16: Writes to the receive buffer are ignored.
// RQ17: Software reads buffer promptly after interrupt.
// RQ18: Line sampled and timed at 32 kHz ticks.
// RQ19: Byte, EOM, ACK load together, then interrupt.
module cecc_ctrl (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Register port.
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Interrupt.
  output logic irq_o,
  // Power mode from the system.
  input wire logic idle_mode_i,
  // Open-drain bus line.
  input wire logic cec_i,
  output logic cec_o,
  output logic cec_oe_o
);
  import cecc_pkg::*;

  function automatic logic addr_claimed(input logic [15:0] map,
                                        input logic [3:0] dest);
    addr_claimed = map[dest];
  endfunction

  // Register group state.
  logic module_en_r, module_en_nxt;
  logic idle_run_r, idle_run_nxt;
  logic [15:0] laddr_map_r, laddr_map_nxt;
  logic rx_en_req_r, rx_en_req_nxt;
  logic [9:0] rxbuf_r, rxbuf_nxt;
  logic [31:0] cfg_r [0:5];
  logic [31:0] cfg_nxt [0:5];
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] imask_r, imask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;

  // Receiver group state.
  cecc_rx_state_e rx_state_r, rx_state_nxt;
  logic [11:0] div_r, div_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [3:0] bit_idx_r, bit_idx_nxt;
  logic [9:0] shift_r, shift_nxt;
  logic first_r, first_nxt;
  logic accept_r, accept_nxt;
  logic ack_ok_r, ack_ok_nxt;
  logic drive_r, drive_nxt;
  logic rx_run_r, rx_run_nxt;
  logic sync1_r, sync2_r, sync3_r;
  logic line_r, line_nxt;

  // Cross-group combinational signals.
  logic active;
  logic soft_rst;
  logic rx_load;
  logic rx_err;
  logic [9:0] rx_word;
  logic tick;
  logic fall;
  logic rise;
  logic [3:0] dest;
  logic acc_now;

  // A disabled module stops everything except its enable register; the
  // idle-run bit additionally keeps the block running in IDLE.
  assign active = module_en_r & (~idle_mode_i | idle_run_r); // RQ2 RQ4
  assign soft_rst = wr_i && module_en_r && (addr_i == CECC_ADDR_SRESET)
    && wdata_i[CECC_SRESET_BIT]; // RQ9 RQ10 RQ11

  // Pin synchroniser: three stages, a change counts when 2 and 3 agree.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end else begin
      sync1_r <= cec_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_comb begin
    line_nxt = (sync2_r == sync3_r) ? sync3_r : line_r;
    fall = line_r & ~line_nxt;
    rise = ~line_r & line_nxt;
    tick = (div_r == CECC_TICK_LAST); // RQ18
    dest = shift_r[4:1];
    acc_now = first_r ? (addr_claimed(laddr_map_r, dest)
                         | (dest == CECC_BROADCAST)) // RQ6 RQ7
                      : accept_r;
    rx_word = {line_r, shift_r[0], shift_r[8:1]}; // RQ15
  end

  always_comb begin
    rx_state_nxt = rx_state_r;
    div_nxt = div_r;
    cnt_nxt = cnt_r;
    bit_idx_nxt = bit_idx_r;
    shift_nxt = shift_r;
    first_nxt = first_r;
    accept_nxt = accept_r;
    ack_ok_nxt = ack_ok_r;
    drive_nxt = drive_r;
    rx_run_nxt = rx_run_r;
    rx_load = 1'b0;
    rx_err = 1'b0;
    if (soft_rst) begin
      rx_state_nxt = CECC_RX_IDLE; // RQ9
      div_nxt = 12'h000;
      cnt_nxt = 8'h00;
      bit_idx_nxt = 4'h0;
      shift_nxt = 10'h000;
      first_nxt = 1'b0;
      accept_nxt = 1'b0;
      ack_ok_nxt = 1'b0;
      drive_nxt = 1'b0; // RQ10
      rx_run_nxt = 1'b0;
    end else if (active) begin
      div_nxt = tick ? 12'h000 : div_r + 12'h001;
      if (tick && cnt_r != 8'hff) begin
        cnt_nxt = cnt_r + 8'h01;
      end
      case (rx_state_r)
        CECC_RX_IDLE: begin
          if (fall && rx_run_r) begin
            rx_state_nxt = CECC_RX_START;
            cnt_nxt = 8'h00;
          end
        end
        CECC_RX_START: begin
          if (rise) begin
            if (cnt_r >= CECC_START_MIN_TICKS) begin
              rx_state_nxt = CECC_RX_WAIT;
              bit_idx_nxt = 4'h0;
              first_nxt = 1'b1;
              cnt_nxt = 8'h00;
            end else begin
              rx_state_nxt = CECC_RX_IDLE;
            end
          end
        end
        CECC_RX_WAIT: begin
          if (fall) begin
            rx_state_nxt = CECC_RX_BIT;
            cnt_nxt = 8'h00;
            // The follower pulls the acknowledge slot low; with map bit
            // 15 set this applies to broadcasts as well.
            if (bit_idx_r == CECC_LAST_BIT) begin
              drive_nxt = first_r ? addr_claimed(laddr_map_r, dest)
                                  : ack_ok_r; // RQ8
            end
          end else if (tick && cnt_r >= CECC_TIMEOUT_TICKS) begin
            rx_state_nxt = CECC_RX_IDLE;
            rx_err = (bit_idx_r != 4'h0);
          end
        end
        CECC_RX_BIT: begin
          if (tick && cnt_r == CECC_SAMPLE_TICKS) begin
            rx_state_nxt = CECC_RX_WAIT;
            if (bit_idx_r == CECC_LAST_BIT) begin
              bit_idx_nxt = 4'h0;
              first_nxt = 1'b0;
              if (first_r) begin
                accept_nxt = acc_now;
                ack_ok_nxt = addr_claimed(laddr_map_r, dest);
              end
              rx_load = acc_now; // RQ19
              shift_nxt = 10'h000;
            end else begin
              bit_idx_nxt = bit_idx_r + 4'h1;
              shift_nxt = {shift_r[8:0], line_r};
            end
          end
        end
        default: begin
          rx_state_nxt = CECC_RX_IDLE;
        end
      endcase
      if (drive_r && tick && cnt_r >= CECC_ACK_HOLD_TICKS) begin
        drive_nxt = 1'b0;
      end
      // The enable takes effect on a sample tick, and a new enable only
      // while the receiver is idle, so the read-back lags the write.
      if (tick) begin
        if (!rx_en_req_r) begin
          rx_run_nxt = 1'b0; // RQ12
          rx_state_nxt = CECC_RX_IDLE;
          drive_nxt = 1'b0;
        end else if (rx_state_r == CECC_RX_IDLE) begin
          rx_run_nxt = 1'b1; // RQ12
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_state_r <= CECC_RX_IDLE;
      div_r <= 12'h000;
      cnt_r <= 8'h00;
      bit_idx_r <= 4'h0;
      shift_r <= 10'h000;
      first_r <= 1'b0;
      accept_r <= 1'b0;
      ack_ok_r <= 1'b0;
      drive_r <= 1'b0;
      rx_run_r <= 1'b0;
      line_r <= 1'b1;
    end else begin
      rx_state_r <= rx_state_nxt;
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      bit_idx_r <= bit_idx_nxt;
      shift_r <= shift_nxt;
      first_r <= first_nxt;
      accept_r <= accept_nxt;
      ack_ok_r <= ack_ok_nxt;
      drive_r <= drive_nxt;
      rx_run_r <= rx_run_nxt;
      line_r <= line_nxt;
    end
  end

  // Register file.
  always_comb begin
    logic wr_ok;
    logic [1:0] clr;
    wr_ok = wr_i & module_en_r; // RQ2 RQ3
    clr = 2'b00;
    module_en_nxt = module_en_r;
    idle_run_nxt = idle_run_r;
    laddr_map_nxt = laddr_map_r;
    rx_en_req_nxt = rx_en_req_r;
    rxbuf_nxt = rxbuf_r;
    for (int i = 0; i < 6; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    imask_nxt = imask_r;
    rdata_nxt = 32'h0000_0000;
    if (wr_i && addr_i == CECC_ADDR_ENABLE) begin
      module_en_nxt = wdata_i[CECC_EN_MODULE_BIT]; // RQ5
      idle_run_nxt = wdata_i[CECC_EN_IDLE_BIT]; // RQ4 RQ5
    end else if (wr_ok && addr_i == CECC_ADDR_LADDR) begin
      laddr_map_nxt = wdata_i[15:0]; // RQ6
    end else if (wr_ok && addr_i == CECC_ADDR_RXEN) begin
      rx_en_req_nxt = wdata_i[CECC_RXEN_BIT];
    end else if (wr_ok && addr_i == CECC_ADDR_RCFG1) begin
      cfg_nxt[0] = wdata_i;
    end else if (wr_ok && addr_i == CECC_ADDR_RCFG2) begin
      cfg_nxt[1] = wdata_i;
    end else if (wr_ok && addr_i == CECC_ADDR_RCFG3) begin
      cfg_nxt[2] = wdata_i;
    end else if (wr_ok && addr_i == CECC_ADDR_TXEN) begin
      cfg_nxt[3] = wdata_i;
    end else if (wr_ok && addr_i == CECC_ADDR_TXBUF) begin
      cfg_nxt[4] = wdata_i;
    end else if (wr_ok && addr_i == CECC_ADDR_TXCFG) begin
      cfg_nxt[5] = wdata_i;
    end else if (wr_ok && addr_i == CECC_ADDR_RXSTAT) begin
      clr = wdata_i[1:0];
    end else if (wr_ok && addr_i == CECC_ADDR_IMASK) begin
      imask_nxt = wdata_i[1:0];
    end
    // The receive buffer has no write path at all. RQ16
    if (rx_load) begin
      rxbuf_nxt = rx_word; // RQ19
    end
    // A new event wins over a clear landing in the same cycle.
    stat_nxt = (stat_r & ~clr)
      | {rx_err, rx_load}; // RQ19
    if (soft_rst) begin
      laddr_map_nxt = CECC_LADDR_RST; // RQ11
      rx_en_req_nxt = 1'b0;
      rxbuf_nxt = CECC_RXBUF_RST; // RQ9
      for (int i = 0; i < 6; i++) begin
        cfg_nxt[i] = CECC_CFG_RST;
      end
      stat_nxt = 2'b00;
      imask_nxt = 2'b00;
    end
    if (rd_i) begin
      if (addr_i == CECC_ADDR_ENABLE) begin // RQ1
        rdata_nxt = {30'h0, idle_run_r, module_en_r};
      end else if (addr_i == CECC_ADDR_LADDR) begin
        rdata_nxt = {16'h0, laddr_map_r};
      end else if (addr_i == CECC_ADDR_RXEN) begin
        rdata_nxt = {31'h0, rx_run_r}; // RQ12
      end else if (addr_i == CECC_ADDR_RXBUF) begin
        rdata_nxt = {22'h0, rxbuf_r}; // RQ15
      end else if (addr_i == CECC_ADDR_RCFG1) begin
        rdata_nxt = cfg_r[0];
      end else if (addr_i == CECC_ADDR_RCFG2) begin
        rdata_nxt = cfg_r[1];
      end else if (addr_i == CECC_ADDR_RCFG3) begin
        rdata_nxt = cfg_r[2];
      end else if (addr_i == CECC_ADDR_TXEN) begin
        rdata_nxt = cfg_r[3];
      end else if (addr_i == CECC_ADDR_TXBUF) begin
        rdata_nxt = cfg_r[4];
      end else if (addr_i == CECC_ADDR_TXCFG) begin
        rdata_nxt = cfg_r[5];
      end else if (addr_i == CECC_ADDR_RXSTAT) begin
        rdata_nxt = {30'h0, stat_r};
      end else if (addr_i == CECC_ADDR_IMASK) begin
        rdata_nxt = {30'h0, imask_r};
      end
    end
    irq_nxt = |(stat_nxt & imask_nxt);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      module_en_r <= 1'b0;
      idle_run_r <= 1'b0;
      laddr_map_r <= CECC_LADDR_RST;
      rx_en_req_r <= 1'b0;
      rxbuf_r <= CECC_RXBUF_RST;
      for (int i = 0; i < 6; i++) begin
        cfg_r[i] <= CECC_CFG_RST;
      end
      stat_r <= 2'b00;
      imask_r <= 2'b00;
      rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end else begin
      module_en_r <= module_en_nxt;
      idle_run_r <= idle_run_nxt;
      laddr_map_r <= laddr_map_nxt;
      rx_en_req_r <= rx_en_req_nxt;
      rxbuf_r <= rxbuf_nxt;
      for (int i = 0; i < 6; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
      stat_r <= stat_nxt;
      imask_r <= imask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o = irq_r;
  // Open drain: only ever pulls low.
  assign cec_o = 1'b0;
  assign cec_oe_o = drive_r;

endmodule

`default_nettype wire

// File: testbench/cecc_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cecc_ctrl_checker
  import cecc_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Register port.
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Interrupt, mode and line.
  input wire logic irq_o,
  input wire logic idle_mode_i,
  input wire logic cec_i,
  input wire logic cec_o,
  input wire logic cec_oe_o
);
  logic [1:0] en_r;
  logic [1:0] en_nxt;
  logic [15:0] map_r;
  logic [15:0] map_nxt;
  logic sres;

  // Shadows tie each read back to the writes that shaped it.
  always_comb begin
    sres = wr_i && addr_i == CECC_ADDR_SRESET && wdata_i[0] && en_r[0];
    en_nxt = en_r;
    map_nxt = map_r;
    if (wr_i && addr_i == CECC_ADDR_ENABLE) begin
      en_nxt = wdata_i[1:0];
    end
    if (sres) begin
      map_nxt = 16'h0;
    end else if (wr_i && addr_i == CECC_ADDR_LADDR && en_r[0]) begin
      map_nxt = wdata_i[15:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      en_r <= 2'h0;
      map_r <= 16'h0;
    end else begin
      en_r <= en_nxt;
      map_r <= map_nxt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_rdata_quiet;
    !$past(rd_i) |-> rdata_o == 32'h0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside a read answer");
  property p_en_read;
    rd_i && addr_i == CECC_ADDR_ENABLE |=> rdata_o == {30'h0, $past(en_r)};
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable register read back wrong");
  property p_map_read;
    rd_i && addr_i == CECC_ADDR_LADDR |=> rdata_o == {16'h0, $past(map_r)};
  endproperty
  a_map_read: assert property (p_map_read)
    else $error("address map read back wrong");
  property p_sreset_read;
    rd_i && addr_i == CECC_ADDR_SRESET |=> rdata_o == 32'h0;
  endproperty
  a_sreset_read: assert property (p_sreset_read)
    else $error("soft reset register not read as zero");
  property p_rxbuf_width;
    rd_i && addr_i == CECC_ADDR_RXBUF |=> rdata_o[31:10] == 22'h0;
  endproperty
  a_rxbuf_width: assert property (p_rxbuf_width)
    else $error("receive buffer upper bits not zero");
  property p_rxen_width;
    rd_i && addr_i == CECC_ADDR_RXEN |=> rdata_o[31:1] == 31'h0;
  endproperty
  a_rxen_width: assert property (p_rxen_width)
    else $error("receive enable upper bits not zero");
  property p_line_release;
    sres |=> (!cec_oe_o) [*2];
  endproperty
  a_line_release: assert property (p_line_release)
    else $error("line still driven after soft reset");
  property p_open_drain;
    cec_o == 1'b0 && (!$rose(cec_oe_o) || $past(en_r[0]));
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line output not an open-drain low");
endmodule
bind cecc_ctrl cecc_ctrl_checker u_chk (.clock_i(clock_i), .reset_i(reset_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .idle_mode_i(idle_mode_i),
  .cec_i(cec_i), .cec_o(cec_o), .cec_oe_o(cec_oe_o));
`default_nettype wire

// File: testbench/cecc_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cecc_ctrl_tb;
  import cecc_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic idle_mode_i = 1'b0;
  logic peer_low = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic cec_o;
  logic cec_oe_o;
  logic line;
  logic rd_d = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  int n_mismatch = 0;
  int num_checks = 0;

  always #5 clock_i = ~clock_i;

  cecc_ctrl uut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .idle_mode_i(idle_mode_i), .cec_i(line), .cec_o(cec_o),
    .cec_oe_o(cec_oe_o));
  cecc_line_model u_line (.dut_oe_i(cec_oe_o), .peer_low_i(peer_low),
    .line_o(line));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The answer stands in the cycle after the strobe; the oldest note wins.
  always @(posedge clock_i) begin
    if (rd_d) begin
      chk(rdata_o, exp_q.pop_front());
    end
    rd_d <= rd_i;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // Receiver state follows its request only at a sampling tick.
  task automatic wait_tick();
    repeat (3300) @(posedge clock_i);
  endtask

  task automatic done(input string name);
    $display("test %0s done", name);
  endtask

  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    void'($urandom(99330));
    for (int i = 0; i < 15; i++) begin
      rd(CECC_ADDR_ENABLE + 32'(4 * i), 32'h0);
    end
    done("reset values");
    r = $urandom();
    wr(CECC_ADDR_LADDR, r);
    rd(CECC_ADDR_LADDR, 32'h0);
    done("disabled writes");
    wr(CECC_ADDR_ENABLE, 32'h3);
    rd(CECC_ADDR_ENABLE, 32'h3);
    wr(CECC_ADDR_LADDR, r);
    rd(CECC_ADDR_LADDR, {16'h0, r[15:0]});
    for (int i = 0; i < 6; i++) begin
      wr(CECC_ADDR_RCFG1 + 32'(4 * i), r ^ 32'(i));
      rd(CECC_ADDR_RCFG1 + 32'(4 * i), r ^ 32'(i));
    end
    wr(CECC_ADDR_RXBUF, 32'h0000_03ff);
    rd(CECC_ADDR_RXBUF, 32'h0);
    wr(CECC_ADDR_IMASK, 32'h0000_0003);
    rd(CECC_ADDR_IMASK, 32'h0000_0003);
    wr(CECC_ADDR_RXSTAT, 32'h0000_0003);
    rd(CECC_ADDR_RXSTAT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(CECC_ADDR_TXSTAT, r);
    rd(CECC_ADDR_TXSTAT, 32'h0);
    done("register access");
    wr(CECC_ADDR_ENABLE, 32'h0);
    rd(CECC_ADDR_LADDR, {16'h0, r[15:0]});
    rd(CECC_ADDR_RCFG2, r ^ 32'h1);
    done("kept while disabled");
    wr(CECC_ADDR_ENABLE, 32'h1);
    idle_mode_i <= 1'b1;
    wr(CECC_ADDR_RXEN, 32'h1);
    wait_tick();
    rd(CECC_ADDR_RXEN, 32'h0);
    wr(CECC_ADDR_ENABLE, 32'h3);
    wait_tick();
    rd(CECC_ADDR_RXEN, 32'h1);
    idle_mode_i <= 1'b0;
    wr(CECC_ADDR_RXEN, 32'h0);
    wait_tick();
    rd(CECC_ADDR_RXEN, 32'h0);
    done("receive enable");
    wr(CECC_ADDR_SRESET, 32'h1);
    rd(CECC_ADDR_LADDR, 32'h0);
    rd(CECC_ADDR_RCFG3, 32'h0);
    rd(CECC_ADDR_RXBUF, 32'h0);
    rd(CECC_ADDR_ENABLE, 32'h3);
    rd(CECC_ADDR_SRESET, 32'h0);
    rd(CECC_ADDR_IMASK, 32'h0);
    rd(CECC_ADDR_TXCFG, 32'h0);
    chk({30'h0, cec_oe_o, line}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    done("soft reset");
    end_of_test();
  end
endmodule
`default_nettype wire

// File: testbench/cecc_line_model.sv
`timescale 1ns/100ps
`default_nettype none
// Other bus devices: the line idles high through the pull-up.
module cecc_line_model (
  // Driven pulls from both sides.
  input wire logic dut_oe_i,
  input wire logic peer_low_i,
  // Resolved wire level.
  output logic line_o
);
  // Any party pulling wins; nobody pulling leaves the pull-up level.
  assign line_o = !(dut_oe_i || peer_low_i);
endmodule
`default_nettype wire
